// *** sfu_pkg.sv ***
// Constants and carrier types of the command engine.
// Assumes one clock domain.
package sfu_pkg;

	localparam logic [7:0]  SFU_HDR_LO      = 8'he4;
	localparam logic [7:0]  SFU_HDR_HI      = 8'h1b;
	localparam logic [7:0]  SFU_FTR_LO      = 8'h1b;
	localparam logic [7:0]  SFU_FTR_HI      = 8'he4;
	localparam logic [7:0]  SFU_ACK         = 8'h2d;
	localparam logic [7:0]  SFU_NAK         = 8'ha5;
	localparam logic [7:0]  SFU_BAUD_LOWER  = 8'h61;
	localparam logic [7:0]  SFU_BAUD_UPPER  = 8'h41;

	localparam logic [15:0] SFU_CMD_UPDATE  = 16'h0100;
	localparam logic [15:0] SFU_CMD_ERASE   = 16'h0300;
	localparam logic [15:0] SFU_CMD_VERIFY  = 16'h0500;
	localparam logic [15:0] SFU_CMD_UNLK1   = 16'h000a;
	localparam logic [15:0] SFU_CMD_UNLK2   = 16'h000b;
	localparam logic [15:0] SFU_CMD_RUN     = 16'h000e;
	localparam logic [15:0] SFU_CMD_RESET   = 16'h000f;
	localparam logic [15:0] SFU_CMD_RUN2    = 16'h0004;
	localparam logic [15:0] SFU_CMD_RESET2  = 16'h0007;

	localparam logic [15:0] SFU_RES_OK      = 16'h1000;
	localparam logic [15:0] SFU_RES_ERASE   = 16'h2000;
	localparam logic [15:0] SFU_RES_VERIFY  = 16'h3000;
	localparam logic [15:0] SFU_RES_PROGRAM = 16'h4000;
	localparam logic [15:0] SFU_RES_CMD     = 16'h5000;
	localparam logic [15:0] SFU_RES_UNLOCK  = 16'h6000;
	localparam logic [31:0] SFU_NO_ERR_ADDR = 32'h12345678;

	localparam logic [15:0] SFU_STAT_LEN    = 16'h0006;
	localparam logic [4:0]  SFU_STAT_LAST   = 5'h0f;
	localparam logic [15:0] SFU_BUF_BYTES   = 16'h0010;
	localparam int          SFU_SECTORS     = 32;

	// Receive framing phases.
	localparam logic [3:0]  SFU_PH_HDR0 = 4'h0;
	localparam logic [3:0]  SFU_PH_HDR1 = 4'h1;
	localparam logic [3:0]  SFU_PH_LEN0 = 4'h2;
	localparam logic [3:0]  SFU_PH_LEN1 = 4'h3;
	localparam logic [3:0]  SFU_PH_CMD0 = 4'h4;
	localparam logic [3:0]  SFU_PH_CMD1 = 4'h5;
	localparam logic [3:0]  SFU_PH_DATA = 4'h6;
	localparam logic [3:0]  SFU_PH_CK0  = 4'h7;
	localparam logic [3:0]  SFU_PH_CK1  = 4'h8;
	localparam logic [3:0]  SFU_PH_FT0  = 4'h9;
	localparam logic [3:0]  SFU_PH_FT1  = 4'ha;

	typedef enum logic [3:0] {
		SFU_S_SETUP  = 4'b0000,
		SFU_S_BAUD   = 4'b0001,
		SFU_S_RXPKT  = 4'b0010,
		SFU_S_ACK    = 4'b0011,
		SFU_S_EXEC   = 4'b0100,
		SFU_S_IMG    = 4'b0101,
		SFU_S_CSUM   = 4'b0110,
		SFU_S_FLASH  = 4'b0111,
		SFU_S_UNLK   = 4'b1000,
		SFU_S_STAT   = 4'b1001,
		SFU_S_SACK   = 4'b1010,
		SFU_S_CORE2  = 4'b1011,
		SFU_S_OFF    = 4'b1100
	} sfu_state_type;

	typedef enum logic [2:0] {
		SFU_OP_NONE   = 3'b000,
		SFU_OP_ERMASK = 3'b001,
		SFU_OP_ERSECT = 3'b010,
		SFU_OP_PROG   = 3'b011,
		SFU_OP_CHECK  = 3'b100,
		SFU_OP_CMP    = 3'b101
	} sfu_op_type;

	typedef struct packed {
		logic        pll;
		logic        serial_port_a;
		logic        pump_claim;
	} sfu_setup_type;

	typedef struct packed {
		logic        valid;
		sfu_op_type  op;
		logic [31:0] addr;
		logic [31:0] mask;
		logic [4:0]  sector;
	} sfu_flash_req_type;

	typedef struct packed {
		logic        done;
		logic        ok;
		logic [31:0] fail_addr;
	} sfu_flash_rsp_type;

	typedef struct packed {
		logic        blk_end;
		logic        img_end;
		logic [31:0] blk_addr;
		logic [4:0]  blk_sector;
		logic [31:0] entry;
	} sfu_img_type;

endpackage

// *** sfu_engine.sv ***
// Device-side flash-update command engine.
// Assumes valid/ready byte ports, an image parser marking block ends
// and a flash agent doing one operation per request.
`timescale 1ns/1ps
`default_nettype none

// Operation
// [RULE_01] Request clock, serial port and pump set-up before any traffic.
// [RULE_02] Wait for 'a' or 'A' to lock baud rate, then enter loop.
// [RULE_03] Loop receiving, executing and reporting until run or reset command.
// [RULE_04] Every received packet gets exactly one ACK or NAK byte.
// [RULE_05] Every command except run and reset ends with a status packet.
// [RULE_06] Status data is 16-bit result then 32-bit address.
// [RULE_07] On failure the address is the location of the first failure.
// [RULE_08] Success outside firmware update reports address 0x12345678.
// [RULE_09] Frame: header 0x1BE4, length, command, data, checksum, footer 0xE41B.
// [RULE_10] Checksum sums command and data bytes only.
// [RULE_11] Words travel low byte first, then high byte.
// [RULE_12] ACK is 0x2D, NAK is 0xA5.
// [RULE_13] Image accepted bytewise; block checksum returned after each block.
// [RULE_14] Erase sector only if not yet erased, then program data and ECC.
// [RULE_15] After programming, read back and check data and ECC.
// [RULE_16] Code 0x0100 updates firmware; success address is image entry point.
// [RULE_17] Code 0x0300 erases sectors named by its 32-bit data.
// [RULE_18] Code 0x0500 compares image to flash without erasing or programming.
// [RULE_19] Codes 0x000A/0x000B load 128-bit key into zone one/two, report unlock.
// [RULE_20] Code 0x000E branches to its address, leaves loop, no status.
// [RULE_21] Code 0x000F leaves loop and lets the watchdog reset the device.
// [RULE_22] Dual-core codes 0x0004/0x0007 hand over to second core, then branch/reset.
// [RULE_23] Status packet uses host framing and carries the completed command code.
// [RULE_24] Result codes 0x1000 to 0x6000 as defined.
// [RULE_25] Erase data bit n selects sector n; set bit erases.
// [RULE_26] Bad header, footer or checksum is answered NAK and not executed.
module sfu_engine
	import sfu_pkg::*;
#(
	parameter bit DUAL_CORE = 1'b0
) (
	input  wire logic              clk,
	input  wire logic              sys_rst,
	output logic                   setup_req_o,
	output sfu_setup_type          setup_o,
	input  wire logic              setup_done_i,
	output logic                   baud_lock_o,
	input  wire logic              rx_valid_i,
	input  wire logic [7:0]        rx_data_i,
	output logic                   rx_ready_o,
	output logic                   tx_valid_o,
	output logic [7:0]             tx_data_o,
	input  wire logic              tx_ready_i,
	output logic                   img_valid_o,
	output logic [7:0]             img_data_o,
	input  wire sfu_img_type       img_i,
	output sfu_flash_req_type      flash_req_o,
	input  wire sfu_flash_rsp_type flash_rsp_i,
	output logic                   key_load_o,
	output logic                   key_zone_o,
	output logic [127:0]           key_o,
	input  wire logic              key_done_i,
	input  wire logic              zone_unlocked_i,
	output logic                   run_o,
	output logic [31:0]            run_addr_o,
	output logic                   reset_req_o,
	output logic                   pump_release_o,
	output logic                   core2_boot_o,
	output logic                   core2_handoff_o,
	input  wire logic              core2_signal_i
);

	typedef struct packed {
		sfu_state_type         st;
		logic [3:0]            ph;
		logic [15:0]           len;
		logic [15:0]           cnt;
		logic [15:0]           cmd;
		logic [15:0]           csum;
		logic [15:0]           rx_ck;
		logic                  bad;
		logic [127:0]          buf_data;
		logic [4:0]            tx_idx;
		logic [7:0]            tx_byte;
		logic                  tx_busy;
		logic                  pkt_ok;
		logic [15:0]           res;
		logic [31:0]           addr;
		logic [15:0]           blk_sum;
		logic [31:0]           blk_addr;
		logic [4:0]            blk_sector;
		logic                  img_fin;
		logic [1:0]            fphase;
		logic                  waiting;
		logic [SFU_SECTORS-1:0] erased;
		sfu_flash_req_type     freq;
		logic                  baud_lock;
		logic                  img_valid;
		logic [7:0]            img_data;
		logic                  key_load;
		logic                  key_zone;
		logic                  run;
		logic [31:0]           run_addr;
		logic                  reset_req;
		logic                  core2;
	} sfu_regs_type;

	sfu_regs_type s_q;
	sfu_regs_type s_d;
	logic         rx_take;
	logic         tx_take;

	// Status packet byte idx, words low byte first.
	function automatic logic [7:0] stat_byte(input logic [15:0] cmd, input logic [15:0] res,
			input logic [31:0] addr, input logic [4:0] idx);
		logic [15:0] ck;
		ck = 16'(cmd[7:0]) + 16'(cmd[15:8]) + 16'(res[7:0]) + 16'(res[15:8])
			+ 16'(addr[7:0]) + 16'(addr[15:8]) + 16'(addr[23:16]) + 16'(addr[31:24]); // [RULE_10]
		case (idx)
			5'd0: stat_byte = SFU_HDR_LO; // [RULE_09] [RULE_11]
			5'd1: stat_byte = SFU_HDR_HI;
			5'd2: stat_byte = SFU_STAT_LEN[7:0];
			5'd3: stat_byte = SFU_STAT_LEN[15:8];
			5'd4: stat_byte = cmd[7:0]; // [RULE_23]
			5'd5: stat_byte = cmd[15:8];
			5'd6: stat_byte = res[7:0]; // [RULE_06]
			5'd7: stat_byte = res[15:8];
			5'd8: stat_byte = addr[7:0];
			5'd9: stat_byte = addr[15:8];
			5'd10: stat_byte = addr[23:16];
			5'd11: stat_byte = addr[31:24];
			5'd12: stat_byte = ck[7:0];
			5'd13: stat_byte = ck[15:8];
			5'd14: stat_byte = SFU_FTR_LO;
			default: stat_byte = SFU_FTR_HI;
		endcase
	endfunction

	assign rx_take = rx_valid_i && rx_ready_o;
	assign tx_take = s_q.tx_busy && tx_ready_i;

	always_comb begin
		rx_ready_o = (s_q.st == SFU_S_BAUD) || (s_q.st == SFU_S_RXPKT) || (s_q.st == SFU_S_SACK)
			|| (s_q.st == SFU_S_IMG && !img_i.blk_end && !img_i.img_end);
	end

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d = s_q;
		s_d.img_valid = 1'b0;
		s_d.key_load = 1'b0;
		s_d.run = 1'b0;
		s_d.freq.valid = 1'b0;
		case (s_q.st)
			SFU_S_SETUP: begin
				if (setup_done_i) begin
					s_d.st = SFU_S_BAUD; // [RULE_01]
				end
			end
			SFU_S_BAUD: begin
				if (rx_take && (rx_data_i == SFU_BAUD_LOWER || rx_data_i == SFU_BAUD_UPPER)) begin
					s_d.baud_lock = 1'b1; // [RULE_02]
					s_d.st = SFU_S_RXPKT;
					s_d.ph = SFU_PH_HDR0;
				end
			end
			SFU_S_RXPKT: begin
				if (rx_take) begin
					s_d.ph = s_q.ph + 4'h1;
					case (s_q.ph)
						SFU_PH_HDR0: begin
							s_d.bad = (rx_data_i != SFU_HDR_LO); // [RULE_26]
							s_d.csum = 16'h0000;
							s_d.buf_data = '0;
						end
						SFU_PH_HDR1: s_d.bad = s_q.bad || (rx_data_i != SFU_HDR_HI);
						SFU_PH_LEN0: s_d.len[7:0] = rx_data_i;
						SFU_PH_LEN1: begin
							s_d.len[15:8] = rx_data_i;
							// Data longer than the key buffer is refused, not truncated.
							if ({rx_data_i, s_q.len[7:0]} > SFU_BUF_BYTES) begin
								s_d.bad = 1'b1;
							end
						end
						SFU_PH_CMD0: begin
							s_d.cmd[7:0] = rx_data_i;
							s_d.csum = s_q.csum + 16'(rx_data_i); // [RULE_10]
						end
						SFU_PH_CMD1: begin
							s_d.cmd[15:8] = rx_data_i;
							s_d.csum = s_q.csum + 16'(rx_data_i);
							s_d.cnt = 16'h0000;
							if (s_q.len == 16'h0000) begin
								s_d.ph = SFU_PH_CK0;
							end
						end
						SFU_PH_DATA: begin
							if (s_q.cnt < SFU_BUF_BYTES) begin
								s_d.buf_data[8*s_q.cnt[3:0] +: 8] = rx_data_i;
							end
							s_d.csum = s_q.csum + 16'(rx_data_i);
							s_d.cnt = s_q.cnt + 16'h0001;
							s_d.ph = (s_q.cnt + 16'h0001 == s_q.len) ? SFU_PH_CK0 : SFU_PH_DATA;
						end
						SFU_PH_CK0: s_d.rx_ck[7:0] = rx_data_i; // [RULE_11]
						SFU_PH_CK1: s_d.rx_ck[15:8] = rx_data_i;
						SFU_PH_FT0: s_d.bad = s_q.bad || (rx_data_i != SFU_FTR_LO);
						default: begin
							s_d.pkt_ok = !s_q.bad && (rx_data_i == SFU_FTR_HI) && (s_q.rx_ck == s_q.csum); // [RULE_26]
							s_d.tx_byte = s_d.pkt_ok ? SFU_ACK : SFU_NAK; // [RULE_04] [RULE_12]
							s_d.tx_busy = 1'b1;
							s_d.st = SFU_S_ACK;
							s_d.ph = SFU_PH_HDR0;
						end
					endcase
				end
			end
			SFU_S_ACK: begin
				if (tx_take) begin
					s_d.tx_busy = 1'b0;
					s_d.st = s_q.pkt_ok ? SFU_S_EXEC : SFU_S_RXPKT; // [RULE_26]
				end
			end
			SFU_S_EXEC: begin
				s_d.res = SFU_RES_OK; // [RULE_24]
				s_d.addr = SFU_NO_ERR_ADDR; // [RULE_08]
				s_d.fphase = 2'b00;
				s_d.waiting = 1'b0;
				s_d.blk_sum = 16'h0000;
				s_d.img_fin = 1'b0;
				case (s_q.cmd)
					SFU_CMD_UPDATE, SFU_CMD_VERIFY: s_d.st = SFU_S_IMG; // [RULE_16] [RULE_18]
					SFU_CMD_ERASE: s_d.st = SFU_S_FLASH; // [RULE_17]
					SFU_CMD_UNLK1, SFU_CMD_UNLK2: begin
						s_d.key_load = 1'b1; // [RULE_19]
						s_d.key_zone = (s_q.cmd == SFU_CMD_UNLK2);
						s_d.st = SFU_S_UNLK;
					end
					SFU_CMD_RUN: begin
						s_d.run = 1'b1; // [RULE_20]
						s_d.run_addr = s_q.buf_data[31:0];
						s_d.st = SFU_S_OFF; // [RULE_03]
					end
					SFU_CMD_RESET: begin
						s_d.reset_req = 1'b1; // [RULE_21]
						s_d.st = SFU_S_OFF;
					end
					SFU_CMD_RUN2, SFU_CMD_RESET2: begin
						if (DUAL_CORE) begin
							s_d.core2 = 1'b1; // [RULE_22]
							s_d.st = SFU_S_CORE2;
						end else begin
							s_d.res = SFU_RES_CMD;
							s_d.st = SFU_S_STAT;
						end
					end
					default: begin
						s_d.res = SFU_RES_CMD; // [RULE_24]
						s_d.st = SFU_S_STAT;
					end
				endcase
				if (s_d.st == SFU_S_STAT) begin
					s_d.tx_idx = 5'd0;
					s_d.tx_byte = SFU_HDR_LO;
					s_d.tx_busy = 1'b1;
				end
			end
			SFU_S_IMG: begin
				if (img_i.blk_end || img_i.img_end) begin
					// A block end goes first; an image end with it is remembered.
					s_d.img_fin = img_i.img_end;
					if (img_i.img_end && s_q.cmd == SFU_CMD_UPDATE) begin
						s_d.addr = img_i.entry; // [RULE_16]
					end
					if (img_i.blk_end) begin
						s_d.blk_addr = img_i.blk_addr;
						s_d.blk_sector = img_i.blk_sector;
						s_d.tx_byte = s_q.blk_sum[7:0]; // [RULE_13] [RULE_11]
						s_d.tx_idx = 5'd0;
						s_d.tx_busy = 1'b1;
						s_d.st = SFU_S_CSUM;
					end else begin
						s_d.tx_idx = 5'd0;
						s_d.tx_byte = SFU_HDR_LO;
						s_d.tx_busy = 1'b1;
						s_d.st = SFU_S_STAT; // [RULE_05]
					end
				end else if (rx_take) begin
					s_d.img_valid = 1'b1; // [RULE_13]
					s_d.img_data = rx_data_i;
					s_d.blk_sum = s_q.blk_sum + 16'(rx_data_i);
				end
			end
			SFU_S_CSUM: begin
				if (tx_take) begin
					s_d.tx_idx = s_q.tx_idx + 5'd1;
					s_d.tx_byte = s_q.blk_sum[15:8];
					if (s_q.tx_idx == 5'd1) begin
						s_d.tx_busy = 1'b0;
						s_d.blk_sum = 16'h0000;
						s_d.fphase = 2'b00;
						s_d.waiting = 1'b0;
						s_d.st = SFU_S_FLASH;
					end
				end
			end
			SFU_S_FLASH: begin
				if (!s_q.waiting) begin
					s_d.waiting = 1'b1;
					s_d.freq.valid = 1'b1;
					s_d.freq.addr = s_q.blk_addr;
					s_d.freq.sector = s_q.blk_sector;
					s_d.freq.mask = s_q.buf_data[31:0]; // [RULE_25]
					if (s_q.cmd == SFU_CMD_ERASE) begin
						s_d.freq.op = SFU_OP_ERMASK; // [RULE_17]
					end else if (s_q.cmd == SFU_CMD_VERIFY) begin
						s_d.freq.op = SFU_OP_CMP; // [RULE_18]
					end else if (s_q.fphase == 2'b00) begin
						if (s_q.erased[s_q.blk_sector]) begin
							s_d.freq.valid = 1'b0; // [RULE_14]
							s_d.waiting = 1'b0;
							s_d.fphase = 2'b01;
						end
						s_d.freq.op = SFU_OP_ERSECT;
					end else if (s_q.fphase == 2'b01) begin
						s_d.freq.op = SFU_OP_PROG; // [RULE_14]
					end else begin
						s_d.freq.op = SFU_OP_CHECK; // [RULE_15]
					end
				end else if (flash_rsp_i.done) begin
					s_d.waiting = 1'b0;
					if (!flash_rsp_i.ok) begin
						s_d.addr = flash_rsp_i.fail_addr; // [RULE_07]
						case (s_q.freq.op)
							SFU_OP_ERMASK, SFU_OP_ERSECT: s_d.res = SFU_RES_ERASE;
							SFU_OP_PROG: s_d.res = SFU_RES_PROGRAM;
							default: s_d.res = SFU_RES_VERIFY;
						endcase
						s_d.st = SFU_S_STAT;
					end else begin
						if (s_q.freq.op == SFU_OP_ERMASK) begin
							s_d.erased = s_q.erased | s_q.freq.mask; // [RULE_25]
						end
						if (s_q.freq.op == SFU_OP_ERSECT) begin
							s_d.erased[s_q.blk_sector] = 1'b1;
						end
						s_d.fphase = s_q.fphase + 2'b01;
						if (s_q.freq.op == SFU_OP_ERMASK) begin
							s_d.st = SFU_S_STAT;
						end else if (s_q.freq.op == SFU_OP_CMP || s_q.freq.op == SFU_OP_CHECK) begin
							s_d.st = s_q.img_fin ? SFU_S_STAT : SFU_S_IMG;
						end
					end
					// A failure stops the image, so its address is the first one.
					if (s_d.st == SFU_S_STAT) begin
						s_d.tx_idx = 5'd0;
						s_d.tx_byte = SFU_HDR_LO;
						s_d.tx_busy = 1'b1;
					end
				end
			end
			SFU_S_UNLK: begin
				if (key_done_i) begin
					s_d.res = zone_unlocked_i ? SFU_RES_OK : SFU_RES_UNLOCK; // [RULE_19]
					s_d.tx_idx = 5'd0;
					s_d.tx_byte = SFU_HDR_LO;
					s_d.tx_busy = 1'b1;
					s_d.st = SFU_S_STAT;
				end
			end
			SFU_S_STAT: begin
				if (tx_take) begin
					s_d.tx_idx = s_q.tx_idx + 5'd1;
					s_d.tx_byte = stat_byte(s_q.cmd, s_q.res, s_q.addr, s_q.tx_idx + 5'd1); // [RULE_05]
					if (s_q.tx_idx == SFU_STAT_LAST) begin
						s_d.tx_busy = 1'b0;
						s_d.st = SFU_S_SACK;
					end
				end
			end
			SFU_S_SACK: begin
				// A host NAK on the status packet resends it.
				if (rx_take) begin
					if (rx_data_i == SFU_NAK) begin
						s_d.tx_idx = 5'd0;
						s_d.tx_byte = SFU_HDR_LO;
						s_d.tx_busy = 1'b1;
						s_d.st = SFU_S_STAT; // [RULE_04]
					end else begin
						s_d.st = SFU_S_RXPKT; // [RULE_03]
					end
				end
			end
			SFU_S_CORE2: begin
				if (core2_signal_i) begin
					if (s_q.cmd == SFU_CMD_RUN2) begin
						s_d.run = 1'b1; // [RULE_22]
						s_d.run_addr = s_q.buf_data[31:0];
					end else begin
						s_d.reset_req = 1'b1;
					end
					s_d.st = SFU_S_OFF;
				end
			end
			SFU_S_OFF: s_d.st = SFU_S_OFF;
			default: s_d.st = SFU_S_SETUP;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign setup_req_o            = (s_q.st == SFU_S_SETUP); // [RULE_01]
	assign setup_o.pll            = 1'b1;
	assign setup_o.serial_port_a  = 1'b1;
	assign setup_o.pump_claim     = !s_q.core2;
	assign baud_lock_o            = s_q.baud_lock;
	assign tx_valid_o             = s_q.tx_busy;
	assign tx_data_o              = s_q.tx_byte;
	assign img_valid_o            = s_q.img_valid;
	assign img_data_o             = s_q.img_data;
	assign flash_req_o            = s_q.freq;
	assign key_load_o             = s_q.key_load;
	assign key_zone_o             = s_q.key_zone;
	assign key_o                  = s_q.buf_data;
	assign run_o                  = s_q.run;
	assign run_addr_o             = s_q.run_addr;
	assign reset_req_o            = s_q.reset_req;
	assign pump_release_o         = s_q.core2;
	assign core2_boot_o           = s_q.core2;
	assign core2_handoff_o        = s_q.core2;

endmodule

`default_nettype wire

// *** sfu_properties.sv ***
// Port checks of the command engine.
// Assumes the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sfu_properties
	import sfu_pkg::*;
(
	input wire logic              clk,
	input wire logic              sys_rst,
	input wire logic              setup_req_o,
	input wire logic              baud_lock_o,
	input wire logic              rx_valid_i,
	input wire logic              rx_ready_o,
	input wire logic              tx_valid_o,
	input wire logic [7:0]        tx_data_o,
	input wire logic              tx_ready_i,
	input wire logic              img_valid_o,
	input wire sfu_flash_req_type flash_req_o,
	input wire logic              key_load_o,
	input wire logic              run_o,
	input wire logic              reset_req_o
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////////////////////////////////////////
	chk_setup_quiet: assert property (setup_req_o |-> !rx_ready_o && !tx_valid_o)
		else $error("traffic in set-up");
	chk_baud_first: assert property (!baud_lock_o |-> !tx_valid_o)
		else $error("tx before lock");
	chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
		else $error("tx byte not held");
	chk_run_quiet: assert property ($rose(run_o) |=> (!tx_valid_o && !rx_ready_o) [*8])
		else $error("traffic after run");
	chk_reset_stays: assert property (reset_req_o |=> reset_req_o && !rx_ready_o && !tx_valid_o)
		else $error("resumed after reset");
	chk_key_pulse: assert property (key_load_o |=> !key_load_o)
		else $error("long key load");
	chk_flash_pulse: assert property (flash_req_o.valid |=> !flash_req_o.valid)
		else $error("long flash request");
	chk_img_follow: assert property (img_valid_o |-> $past(rx_valid_i && rx_ready_o))
		else $error("image byte not received");
endmodule

bind sfu_engine sfu_properties u_chk (.clk, .sys_rst, .setup_req_o, .baud_lock_o, .rx_valid_i, .rx_ready_o,
	.tx_valid_o, .tx_data_o, .tx_ready_i, .img_valid_o, .flash_req_o, .key_load_o, .run_o, .reset_req_o);
`default_nettype wire

// *** sfu_host_model.sv ***
// Host model: frames packets and gathers the replies.
// Drives only at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module sfu_host_model (
	input  wire logic       clk,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	input  wire logic       rx_ready,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready
);
	logic [7:0] got[$];
	logic       slow = 1'b0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end
	// A slow host stalls every other cycle.
	always @(negedge clk) tx_ready <= slow ? ~tx_ready : 1'b1;
	always @(posedge clk) if (tx_valid && tx_ready) got.push_back(tx_data);
	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Idle data is the inverse of the last byte, so a late sample shows.
	task automatic send(input logic [7:0] b);
		@(negedge clk);
		rx_valid <= 1'b1;
		rx_data <= b;
		#1;
		while (!rx_ready) begin
			@(negedge clk);
			#1;
		end
		@(negedge clk);
		rx_valid <= 1'b0;
		rx_data <= ~b;
	endtask
	// Bit 0 of bad spoils the checksum, bit 1 the footer.
	task automatic send_pkt(input logic [15:0] c, input logic [7:0] d[$], input logic [1:0] bad);
		logic [15:0] ck;
		logic [7:0]  p[$];
		ck = c[7:0] + c[15:8];
		foreach (d[i]) ck += d[i];
		ck ^= 16'(bad[0]);
		p = '{8'he4, 8'h1b, 8'(d.size()), 8'h00, c[7:0], c[15:8]};
		p = {p, d, ck[7:0], ck[15:8], 8'h1b, 8'he4 ^ 8'(bad[1])};
		foreach (p[i]) send(p[i]);
	endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench of the command engine with host, flash and key agents.
// The bench plays the image parser.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import sfu_pkg::*;
;
	logic              clk = 1'b0;
	logic              sys_rst = 1'b1;
	logic              setup_done = 1'b0;
	logic              rx_valid, rx_ready, tx_valid, tx_ready, baud_lock, run, reset_req, key_load, key_zone;
	logic [7:0]        rx_data, tx_data, img_data;
	logic [127:0]      key;
	logic [31:0]       run_addr, mask;
	logic              key_done = 1'b0;
	logic              unlocked = 1'b0;
	logic              flash_ok = 1'b1;
	logic [31:0]       fail_addr = 32'h0;
	sfu_img_type       img = '0;
	sfu_flash_req_type freq;
	sfu_flash_rsp_type frsp = '0;
	sfu_op_type        ops[$];
	int                n_errors = 0;
	int                tests_run = 0;
	always #4 clk = ~clk;
	// Flash and key agents answer one cycle later.
	always @(negedge clk) begin
		frsp <= '{freq.valid, flash_ok, fail_addr};
		key_done <= key_load;
		if (freq.valid) begin
			ops.push_back(freq.op);
			mask <= freq.mask;
		end
	end
	sfu_engine u_dut (.clk(clk), .sys_rst(sys_rst), .setup_req_o(), .setup_o(), .setup_done_i(setup_done),
		.baud_lock_o(baud_lock), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_ready_o(rx_ready),
		.tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready), .img_valid_o(), .img_data_o(img_data),
		.img_i(img), .flash_req_o(freq), .flash_rsp_i(frsp), .key_load_o(key_load), .key_zone_o(key_zone),
		.key_o(key), .key_done_i(key_done), .zone_unlocked_i(unlocked), .run_o(run), .run_addr_o(run_addr),
		.reset_req_o(reset_req), .pump_release_o(), .core2_boot_o(), .core2_handoff_o(), .core2_signal_i(1'b0));
	sfu_host_model u_host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
	////////////////////////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic restart(input logic [7:0] b);
		@(negedge clk);
		sys_rst <= 1'b1;
		setup_done <= 1'b0;
		repeat (20) @(negedge clk);
		sys_rst <= 1'b0;
		setup_done <= 1'b1;
		u_host.send(b);
	endtask
	task automatic wait_got(input int n);
		for (int i = 0; i < 3000 && u_host.got.size() < n; i++) @(negedge clk);
	endtask
	task automatic cmd(input logic [15:0] c, input logic [7:0] d[$], input logic [1:0] bad, input int n);
		u_host.got.delete();
		ops.delete();
		u_host.send_pkt(c, d, bad);
		wait_got(n);
		check(u_host.got[0], bad != 2'b00 ? 8'ha5 : 8'h2d);
	endtask
	task automatic stat(input logic [15:0] c, input logic [15:0] r, input logic [31:0] a, input int base,
		input logic [7:0] reply);
		logic [15:0] ck;
		logic [7:0]  e[$];
		ck = c[7:0] + c[15:8] + r[7:0] + r[15:8] + a[7:0] + a[15:8] + a[23:16] + a[31:24];
		e = '{8'he4, 8'h1b, 8'h06, 8'h00, c[7:0], c[15:8], r[7:0], r[15:8], a[7:0], a[15:8], a[23:16], a[31:24],
			ck[7:0], ck[15:8], 8'h1b, 8'he4};
		foreach (e[i]) check(u_host.got[base + i], e[i]);
		u_host.send(reply);
	endtask
	////////////////////////////////////////////////////////////////////////////////////////////////////
	task automatic t_baud();
		restart(8'h78);
		repeat (2) @(negedge clk);
		check(baud_lock, 1'b0);
		u_host.send(8'h61);
		repeat (2) @(negedge clk);
		check(baud_lock, 1'b1);
		restart(8'h41);
		repeat (2) @(negedge clk);
		check(baud_lock, 1'b1);
	endtask
	task automatic t_erase();
		cmd(SFU_CMD_ERASE, '{8'h05, 8'h00, 8'h00, 8'h80}, 2'b00, 17);
		check(mask, 32'h80000005);
		stat(SFU_CMD_ERASE, 16'h1000, 32'h12345678, 1, 8'h2d);
		flash_ok = 1'b0;
		fail_addr = 32'h00082000;
		u_host.slow = 1'b1;
		cmd(SFU_CMD_ERASE, '{8'hff, 8'hff, 8'hff, 8'hff}, 2'b00, 17);
		stat(SFU_CMD_ERASE, 16'h2000, 32'h00082000, 1, 8'h2d);
		flash_ok = 1'b1;
		u_host.slow = 1'b0;
	endtask
	task automatic t_unlock();
		logic [7:0]   d[$];
		logic [127:0] k;
		for (int i = 0; i < 16; i++) begin
			d.push_back(8'(i * 17 + 1));
			k[8*i +: 8] = 8'(i * 17 + 1);
		end
		unlocked = 1'b1;
		cmd(SFU_CMD_UNLK1, d, 2'b00, 17);
		check({key_zone, key}, {1'b0, k});
		stat(SFU_CMD_UNLK1, 16'h1000, 32'h12345678, 1, 8'h2d);
		unlocked = 1'b0;
		cmd(SFU_CMD_UNLK2, d, 2'b00, 17);
		check({key_zone, u_host.got[8], u_host.got[7]}, 17'h16000);
		u_host.send(8'h2d);
	endtask
	task automatic t_bad();
		cmd(SFU_CMD_ERASE, '{8'h01, 8'h00, 8'h00, 8'h00}, 2'b01, 1);
		cmd(SFU_CMD_ERASE, '{8'h01, 8'h00, 8'h00, 8'h00}, 2'b10, 1);
		repeat (50) @(negedge clk);
		check(u_host.got.size() + ops.size(), 1);
		cmd(16'h0200, '{}, 2'b00, 17);
		stat(16'h0200, 16'h5000, 32'h12345678, 1, 8'ha5);
		wait_got(33);
		stat(16'h0200, 16'h5000, 32'h12345678, 17, 8'h2d);
	endtask
	task automatic t_image(input logic [15:0] c, input int n_ops, input logic [31:0] a);
		cmd(c, '{}, 2'b00, 1);
		u_host.send(8'h9c);
		u_host.send(8'hb7);
		@(negedge clk);
		img <= '{1'b1, 1'b1, 32'h00084000, 5'd4, 32'h00084010};
		@(negedge clk);
		img <= '0;
		wait_got(19);
		check({u_host.got[2], u_host.got[1]}, 16'h0153);
		check(ops.size(), n_ops);
		check(img_data, 8'hb7);
		check(ops[n_ops - 1], c == SFU_CMD_VERIFY ? SFU_OP_CMP : SFU_OP_CHECK);
		stat(c, 16'h1000, a, 3, 8'h2d);
	endtask
	task automatic t_run();
		cmd(SFU_CMD_RUN, '{8'h00, 8'h40, 8'h08, 8'h00}, 2'b00, 1);
		for (int i = 0; i < 100 && !run; i++) @(negedge clk);
		check({run, run_addr}, 33'h100084000);
		repeat (40) @(negedge clk);
		check(u_host.got.size(), 1);
		restart(8'h61);
		cmd(SFU_CMD_RESET, '{}, 2'b00, 1);
		repeat (4) @(negedge clk);
		check(reset_req, 1'b1);
		repeat (40) @(negedge clk);
		check(u_host.got.size(), 1);
	endtask
	////////////////////////////////////////////////////////////////////////////////////////////////////
	initial begin
		t_baud();
		t_erase();
		t_unlock();
		t_bad();
		t_image(SFU_CMD_UPDATE, 3, 32'h00084010);
		t_image(SFU_CMD_UPDATE, 2, 32'h00084010);
		t_image(SFU_CMD_VERIFY, 1, 32'h12345678);
		t_run();
		conclude();
	end
	// Under a thousand cycles are needed; this leaves margin.
	initial begin
		#400000;
		n_errors++;
		conclude();
	end
endmodule
`default_nettype wire
